// >>> rtl/swt_params.svh
/*
 Register offsets, bit positions, reset values and timing figures
 of the sleep wake timer and battery monitor.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SWT_PARAMS_SVH
`define SWT_PARAMS_SVH

`define SWT_A_STAT1    7'h03
`define SWT_A_STAT2    7'h04
`define SWT_A_IEN2     7'h06
`define SWT_A_CTL1     7'h07
`define SWT_A_WPER     7'h14
`define SWT_A_WTMH     7'h15
`define SWT_A_WTML     7'h16
`define SWT_A_WTVH     7'h17
`define SWT_A_WTVL     7'h18
`define SWT_A_THR      7'h1a
`define SWT_A_VBAT     7'h1b

`define SWT_B_WUT      3
`define SWT_B_LBD      2
`define SWT_B_ENLBD    6
`define SWT_B_ENWT     5
`define SWT_B_X32      4

`define SWT_IEN_RST    4'h3
`define SWT_THR_RST    5'h14
`define SWT_BELOW_NEED 2'h3
`define SWT_PRE_BASE   18'h00004

`define SWT_CLK_NS     10
`define SWT_MEAS_ON_NS 250000
`define SWT_LF_HZ      32768
`define SWT_MEAS_PER_S 1

`endif

// >>> rtl/swt_pkg.sv
/*
 Types of the sleep wake timer and battery monitor.
 Assumes nothing of its surroundings.
*/
package swt_pkg;

  typedef enum logic {SWT_AWAKE, SWT_ASLEEP} swt_mode_t;

  typedef struct packed {
    logic [6:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } swt_reg_req_t;

  typedef struct packed {
    swt_mode_t   mode;
    logic        run;
    logic [17:0] pre;
    logic [15:0] wtv;
    logic [5:0]  wper;
    logic [15:0] wtm;
    logic [4:0]  thr;
    logic [4:0]  vbat;
    logic [3:0]  ien;
    logic        enlbd;
    logic        enwt;
    logic        x32;
    logic        fl_wut;
    logic        fl_lbd;
    logic [15:0] tick;
    logic        meas_on;
    logic [15:0] on_cnt;
    logic [1:0]  below;
    logic [7:0]  rdata;
    logic        irq_n;
    logic        wut_pulse;
    logic        rc_on;
  } swt_state_t;

endpackage : swt_pkg

// >>> rtl/swt_core.sv
/*
 Sleep supervision: wake timer on the low-frequency tick and battery
 monitor with threshold interrupt, reached through a byte register port.
 Assumes oscillator ticks and battery code synchronous to clk_in.
*/
`timescale 1ns/100ps
`default_nettype none
`include "swt_params.svh"

module swt_core #(
  parameter int MEAS_ON_CYC    = `SWT_MEAS_ON_NS / `SWT_CLK_NS,
  parameter int MEAS_PER_TICKS = `SWT_LF_HZ * `SWT_MEAS_PER_S
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  ce_in,
  input  wire logic                  sleep_cmd_in,
  input  wire logic                  rc_tick_in,
  input  wire logic                  xtal32_tick_in,
  input  wire logic [4:0]            batt_code_in,
  input  wire swt_pkg::swt_reg_req_t reg_req_in,
  output logic      [7:0]            reg_rdata_out,
  output logic                       irq_n_out,
  output logic                       asleep_out,
  output logic                       mcu_clk_en_out,
  output logic                       xtal30_en_out,
  output logic                       rc_osc_en_out,
  output logic                       general_pin_zero_xtal_out,
  output logic                       meas_en_out,
  output logic                       wake_expire_out
);

  swt_pkg::swt_state_t s_reg;
  swt_pkg::swt_state_t s_next;

  logic        lf;
  logic        expire;
  logic [17:0] pre_top;
  logic [15:0] on_top;
  logic [15:0] per_top;
  logic [7:0]  rv;

  assign on_top  = 16'(MEAS_ON_CYC - 1);
  assign per_top = 16'(MEAS_PER_TICKS - 1);
  // Prescale of 4 * 2^R ticks per count step
  assign pre_top = (`SWT_PRE_BASE << s_reg.wper[5:2]) - 18'h00001;

  always_comb begin
    s_next      = s_reg;
    expire      = 1'b0;
    rv          = 8'h00;
    s_next.wut_pulse = 1'b0;
    // Crystal replaces RC as tick source
    lf = s_reg.x32 ? xtal32_tick_in : rc_tick_in;

    // Register port
    if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        `SWT_A_IEN2: s_next.ien = reg_req_in.wdata[3:0];
        `SWT_A_CTL1: begin
          s_next.enlbd = reg_req_in.wdata[`SWT_B_ENLBD];
          s_next.enwt  = reg_req_in.wdata[`SWT_B_ENWT];
          s_next.x32   = reg_req_in.wdata[`SWT_B_X32];
        end
        `SWT_A_WPER: s_next.wper = reg_req_in.wdata[5:0];
        `SWT_A_WTMH: s_next.wtm[15:8] = reg_req_in.wdata;
        `SWT_A_WTML: s_next.wtm[7:0] = reg_req_in.wdata;
        `SWT_A_THR:  s_next.thr = reg_req_in.wdata[4:0];
        default: ;
      endcase
    end
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        `SWT_A_STAT2: begin
          rv[`SWT_B_WUT] = s_reg.fl_wut;
          rv[`SWT_B_LBD] = s_reg.fl_lbd;
          // Read clears; later sets still win
          s_next.fl_wut = 1'b0;
          s_next.fl_lbd = 1'b0;
        end
        `SWT_A_IEN2: rv[3:0] = s_reg.ien;
        `SWT_A_CTL1: begin
          rv[`SWT_B_ENLBD] = s_reg.enlbd;
          rv[`SWT_B_ENWT]  = s_reg.enwt;
          rv[`SWT_B_X32]   = s_reg.x32;
        end
        `SWT_A_WPER: rv[5:0] = s_reg.wper;
        `SWT_A_WTMH: rv = s_reg.wtm[15:8];
        `SWT_A_WTML: rv = s_reg.wtm[7:0];
        `SWT_A_WTVH: rv = s_reg.wtv[15:8];
        `SWT_A_WTVL: rv = s_reg.wtv[7:0];
        `SWT_A_THR:  rv[4:0] = s_reg.thr;
        `SWT_A_VBAT: rv[4:0] = s_reg.vbat;
        default: ;
      endcase
      s_next.rdata = rv;
    end

    // Wake timer
    if (s_reg.run && lf) begin
      if (s_reg.pre == pre_top) begin
        s_next.pre = 18'h00000;
        if (s_reg.wtm != 16'h0000 && s_reg.wtv == s_reg.wtm - 16'h0001) begin
          s_next.wtv = 16'h0000;
          expire     = 1'b1;
        end else begin
          s_next.wtv = s_reg.wtv + 16'h0001;
        end
      end else begin
        s_next.pre = s_reg.pre + 18'h00001;
      end
    end
    if (expire) begin
      s_next.fl_wut    = 1'b1;
      s_next.wut_pulse = 1'b1;
    end

    // Battery monitor
    if (!s_reg.enlbd) begin
      s_next.tick    = 16'h0000;
      s_next.meas_on = 1'b0;
      s_next.on_cnt  = 16'h0000;
      s_next.below   = 2'h0;
    end else if (s_reg.meas_on) begin
      if (s_reg.on_cnt == on_top) begin
        s_next.meas_on = 1'b0;
        s_next.on_cnt  = 16'h0000;
        s_next.vbat    = batt_code_in;
        if (batt_code_in < s_reg.thr) begin
          if (s_reg.below == `SWT_BELOW_NEED) begin
            s_next.fl_lbd = 1'b1;
          end else begin
            s_next.below = s_reg.below + 2'h1;
          end
        end else begin
          s_next.below = 2'h0;
        end
      end else begin
        s_next.on_cnt = s_reg.on_cnt + 16'h0001;
      end
    end else if (lf) begin
      if (s_reg.tick == per_top) begin
        s_next.tick    = 16'h0000;
        s_next.meas_on = 1'b1;
      end else begin
        s_next.tick = s_reg.tick + 16'h0001;
      end
    end

    // Interrupt line
    s_next.irq_n = !((s_next.fl_wut & s_next.ien[`SWT_B_WUT]) |
                     (s_next.fl_lbd & s_next.ien[`SWT_B_LBD]));

    // Mode: sleep only while no enabled interrupt is pending
    unique case (s_reg.mode)
      swt_pkg::SWT_AWAKE: begin
        if (sleep_cmd_in && s_next.irq_n) begin
          s_next.mode = swt_pkg::SWT_ASLEEP;
          if (s_next.enwt) begin
            s_next.run = 1'b1;
            s_next.pre = 18'h00000;
            s_next.wtv = 16'h0000;
          end
        end
      end
      swt_pkg::SWT_ASLEEP: begin
        // Disabled wake interrupt leaves mode alone
        if (!sleep_cmd_in || !s_next.irq_n) begin
          s_next.mode = swt_pkg::SWT_AWAKE;
        end
      end
    endcase
    if (!s_next.enwt) begin
      s_next.run = 1'b0;
    end
    // RC runs for monitor or timer unless crystal chosen
    s_next.rc_on = !s_next.x32 & (s_next.enlbd | s_next.run);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg       <= '0;
      s_reg.thr   <= `SWT_THR_RST;
      s_reg.ien   <= `SWT_IEN_RST;
      s_reg.irq_n <= 1'b1;
    end else if (ce_in) begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata_out   = s_reg.rdata;
  assign irq_n_out       = s_reg.irq_n;
  assign asleep_out      = s_reg.mode;
  assign mcu_clk_en_out  = !s_reg.mode;
  assign xtal30_en_out   = !s_reg.mode;
  assign rc_osc_en_out   = s_reg.rc_on;
  assign general_pin_zero_xtal_out  = s_reg.x32;
  assign meas_en_out     = s_reg.meas_on;
  assign wake_expire_out = s_reg.wut_pulse;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_expire;
    s_reg.wut_pulse && s_reg.ien[`SWT_B_WUT];
  endsequence

  sequence s_woken;
    !irq_n_out && !asleep_out && mcu_clk_en_out;
  endsequence

  sequence s_stat2_read;
    ce_in && reg_req_in.rd && reg_req_in.addr == `SWT_A_STAT2;
  endsequence

  AST_THR_RESET: assert property ($fell(rst_in) |-> s_reg.thr == `SWT_THR_RST)
    else $error("threshold reset value wrong");
  AST_IRQ_LBD: assert property (s_reg.fl_lbd && s_reg.ien[`SWT_B_LBD] |-> !irq_n_out)
    else $error("low battery flag not on irq line");
  AST_VBAT_UPPER: assert property (ce_in && reg_req_in.rd && reg_req_in.addr == `SWT_A_VBAT
    |=> reg_rdata_out == {3'h0, $past(s_reg.vbat)})
    else $error("battery level read wrong");
  AST_MEAS_WIDTH: assert property (s_reg.on_cnt <= on_top && (s_reg.on_cnt == 16'h0000 || meas_en_out))
    else $error("measurement window overran");
  AST_FOUR_READS: assert property ($rose(s_reg.fl_lbd) |-> $past(s_reg.below) == `SWT_BELOW_NEED)
    else $error("low battery flag before four readings");
  AST_RC_ON: assert property (s_reg.enlbd && !s_reg.x32 |-> rc_osc_en_out)
    else $error("rc oscillator off while monitoring");
  AST_WUT_WAKE: assert property (s_expire |-> s_woken)
    else $error("wake expiry did not wake");
  AST_STATUS_CLEAR: assert property (s_stat2_read ##1 !s_reg.wut_pulse |-> !s_reg.fl_wut)
    else $error("status read did not clear flag");
  AST_DEFER: assert property (!irq_n_out |-> !asleep_out && xtal30_en_out)
    else $error("sleep while interrupt pending");
  AST_WRAP: assert property (s_reg.wut_pulse |-> s_reg.wtv == 16'h0000 && s_reg.run)
    else $error("timer did not restart at expiry");

endmodule : swt_core

`default_nettype wire

// >>> tb/swt_host.sv
/*
 Host micro model: drives the byte register port, services the interrupt.
 Assumes the core clock and one-cycle request strobes.
*/
`timescale 1ns/100ps
`default_nettype none
`include "swt_params.svh"

module swt_host (
  input  wire logic                 clk_in,
  input  wire logic [7:0]           rdata_in,
  input  wire logic                 irq_n_in,
  output var  swt_pkg::swt_reg_req_t reg_req_out
);
  initial reg_req_out = '0;

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_req_out <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk_in);
    reg_req_out <= '0;
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_in);
    reg_req_out <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk_in);
    reg_req_out <= '0;
    #1 d = rdata_in;
  endtask : rd

  task automatic service(output logic [7:0] st2);
    logic [7:0] st1;
    rd(`SWT_A_STAT1, st1);
    rd(`SWT_A_STAT2, st2);
  endtask : service
endmodule : swt_host
`default_nettype wire

// >>> tb/sleep_wake_timer_battery_monitor_tb.sv
/*
 Self-checking bench of the wake timer and battery monitor core.
 Assumes swt_core, swt_host and small measurement parameters.
*/
`timescale 1ns/100ps
`default_nettype none
`include "swt_params.svh"

module sleep_wake_timer_battery_monitor_tb;
  logic                  clk_in, rst_in, sleep, tck, irq_n, asleep, mclk, x30;
  logic                  rco, g0x, meas, wexp, ce;
  logic [4:0]            batt;
  logic [7:0]            rdata, v;
  swt_pkg::swt_reg_req_t req;
  int                    n_errors = 0;
  int                    cmp_count = 0;
  int                    n_exp = 0;

  swt_core #(.MEAS_ON_CYC(4), .MEAS_PER_TICKS(8)) swt_core_inst (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .sleep_cmd_in(sleep),
    .rc_tick_in(tck), .xtal32_tick_in(1'b0), .batt_code_in(batt),
    .reg_req_in(req), .reg_rdata_out(rdata), .irq_n_out(irq_n),
    .asleep_out(asleep), .mcu_clk_en_out(mclk), .xtal30_en_out(x30),
    .rc_osc_en_out(rco), .general_pin_zero_xtal_out(g0x), .meas_en_out(meas),
    .wake_expire_out(wexp));
  swt_host swt_host_inst (.clk_in(clk_in), .rdata_in(rdata), .irq_n_in(irq_n),
    .reg_req_out(req));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) if (wexp === 1'b1) n_exp++;

  task automatic wrap_up;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_in) tck <= 1'b1;
      @(posedge clk_in) tck <= 1'b0;
    end
    repeat (3) @(posedge clk_in);
    #1;
  endtask : tick

  // One whole measurement window, ticks supplied until it opens
  task automatic meas_once;
    int i;
    for (i = 0; i < 40 && meas !== 1'b1; i++) tick(1);
    if (i == 40) begin
      n_errors++;
      wrap_up();
    end
    for (i = 0; i < 20 && meas === 1'b1; i++) @(posedge clk_in);
    if (i == 20) begin
      n_errors++;
      wrap_up();
    end
    repeat (3) @(posedge clk_in);
  endtask : meas_once

  task automatic t_reset;
    swt_host_inst.rd(`SWT_A_THR, v);
    chk("threshold", v, 8'h14);
    // Clock enable low must swallow the write
    ce <= 1'b0;
    swt_host_inst.wr(`SWT_A_THR, 8'h0a);
    ce <= 1'b1;
    swt_host_inst.rd(`SWT_A_THR, v);
    chk("ce_frozen", v, 8'h14);
    swt_host_inst.rd(`SWT_A_WTML, v);
    chk("mantissa_low", v, 8'h00);
    swt_host_inst.rd(7'h20, v);
    chk("unmapped", v, 8'h00);
  endtask : t_reset

  task automatic t_batt;
    swt_host_inst.wr(`SWT_A_IEN2, 8'h04);
    swt_host_inst.wr(`SWT_A_CTL1, 8'h40);
    sleep <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("rc_osc", {7'h0, rco}, 8'h01);
    meas_once();
    batt <= 5'h05;
    repeat (3) meas_once();
    chk("irq_three_low", {7'h0, irq_n}, 8'h01);
    meas_once();
    chk("irq_four_low", {7'h0, irq_n}, 8'h00);
    swt_host_inst.rd(`SWT_A_VBAT, v);
    chk("level", v, 8'h05);
    sleep <= 1'b0;
    swt_host_inst.service(v);
    chk("status_batt", v, 8'h04);
    chk("irq_released", {7'h0, irq_n}, 8'h01);
    swt_host_inst.wr(`SWT_A_CTL1, 8'h00);
  endtask : t_batt

  task automatic t_wake_irq;
    swt_host_inst.wr(`SWT_A_WPER, 8'h00);
    swt_host_inst.wr(`SWT_A_WTMH, 8'h00);
    swt_host_inst.wr(`SWT_A_WTML, 8'h02);
    swt_host_inst.wr(`SWT_A_IEN2, 8'h08);
    swt_host_inst.wr(`SWT_A_CTL1, 8'h20);
    sleep <= 1'b1;
    repeat (3) @(posedge clk_in);
    tick(7);
    chk("irq_early", {7'h0, irq_n}, 8'h01);
    swt_host_inst.rd(`SWT_A_WTVL, v);
    chk("count_low", v, 8'h01);
    tick(1);
    chk("irq_expired", {7'h0, irq_n}, 8'h00);
    chk("awake", {5'h0, asleep, x30, mclk}, 8'h03);
    swt_host_inst.rd(`SWT_A_WTVH, v);
    chk("count_high", v, 8'h00);
    swt_host_inst.rd(`SWT_A_WTVL, v);
    chk("count_wrap", v, 8'h00);
    sleep <= 1'b0;
    swt_host_inst.service(v);
    chk("status_wake", v, 8'h08);
  endtask : t_wake_irq

  task automatic t_wake_quiet;
    swt_host_inst.wr(`SWT_A_IEN2, 8'h00);
    sleep <= 1'b1;
    repeat (3) @(posedge clk_in);
    tick(8);
    chk("stay_asleep", {6'h0, asleep, irq_n}, 8'h03);
    chk("expiries", n_exp[7:0], 8'h02);
    swt_host_inst.rd(`SWT_A_STAT2, v);
    chk("quiet_flag", v, 8'h08);
    sleep <= 1'b0;
    swt_host_inst.wr(`SWT_A_CTL1, 8'h30);
    repeat (2) @(posedge clk_in);
    chk("pin_zero_xtal", {7'h0, g0x}, 8'h01);
    chk("rc_off_xtal", {7'h0, rco}, 8'h00);
  endtask : t_wake_quiet

  initial begin
    rst_in = 1'b1;
    ce = 1'b1;
    sleep = 1'b0;
    tck = 1'b0;
    batt = 5'h1f;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_batt();
    t_wake_irq();
    t_wake_quiet();
    wrap_up();
  end
endmodule : sleep_wake_timer_battery_monitor_tb
`default_nettype wire
